// ===== core/adc_result_format_window_detect.sv
`timescale 1ns/1ps
// Notes on behaviour
// - right justify: top two bits in high byte
// - right justify: sign-extend differential, zero single-ended
// - left justify: top eight bits in high byte
// - left justify: low two bits high, rest zero
// - single-ended unsigned, differential two's complement
// - compare each new result against limits
// - window flag readable and drives interrupt
// - upper limit bytes reset to all ones
// - lower limit from two writable bytes
// - window flag for inside or outside results
// - justify bit zero right, one left
// - window flag held until software clears
// - done flag sets on busy falling edge
module adc_result_format_window_detect
   import adc_fmt_pkg::*;
#(
   parameter int WIDTH = RESULT_BITS
) (
   input wire logic clk_i,
   input wire logic rst_i,
   // special-function register port
   input wire logic [7:0] sfr_addr_i,
   input wire logic [7:0] sfr_wdata_i,
   input wire logic sfr_wr_i,
   input wire logic sfr_rd_i,
   output logic [7:0] sfr_rdata_o,
   // converter side
   input wire logic conversion_busy_bit_i,
   input wire logic [WIDTH-1:0] code_i,
   input wire logic diff_i,
   output logic window_irq_o,
   output logic done_irq_o,
   output logic justify_select_o
);
   initial begin
      if (WIDTH != 10) $error("block serves a 10-bit converter only");
   end

   ////////////////////////////////////////////////////////////////////////
   // result bytes
   logic [7:0] result_low_byte_r, result_low_byte_nxt;
   logic [7:0] result_high_byte_r, result_high_byte_nxt;

   // limit bytes, kept in the layout of the result word
   logic [7:0] upper_limit_low_byte_r, upper_limit_low_byte_nxt;
   logic [7:0] upper_limit_high_byte_r, upper_limit_high_byte_nxt;
   logic [7:0] lower_limit_low_byte_r, lower_limit_low_byte_nxt;
   logic [7:0] lower_limit_high_byte_r, lower_limit_high_byte_nxt;

   // control register state; spare bits are only stored
   logic left_justify_bit_r, left_justify_bit_nxt;
   logic window_match_flag_r, window_match_flag_nxt;
   logic conversion_done_flag_r, conversion_done_flag_nxt;
   logic [7:0] control_keep_r, control_keep_nxt;

   // converter edge tracking
   logic busy_prev_r, busy_prev_nxt;
   logic new_result;

   // software write strobes, one per register
   logic wr_result_low;
   logic wr_result_high;
   logic wr_upper_low;
   logic wr_upper_high;
   logic wr_lower_low;
   logic wr_lower_high;
   logic wr_control;

   // window compare
   logic [15:0] new_word;
   logic [15:0] upper_word;
   logic [15:0] lower_word;
   logic above;
   logic below;
   logic inside_mode;
   logic match;
   logic [7:0] control_view;

   function automatic logic wr_hit(input logic [7:0] a, input logic [7:0] want, input logic wr);
      wr_hit = wr && (a == want);
   endfunction

   // signed compare when differential, else unsigned (16-bit formatted words)
   function automatic logic less_than(input logic [15:0] a, input logic [15:0] b, input logic sgn);
      if (sgn) begin
         less_than = $signed(a) < $signed(b);
      end else begin
         less_than = a < b;
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // a write is taken on any edge that sees the strobe high
   assign wr_result_low = wr_hit(sfr_addr_i, ADDR_RESULT_LOW, sfr_wr_i);
   assign wr_result_high = wr_hit(sfr_addr_i, ADDR_RESULT_HIGH, sfr_wr_i);
   assign wr_upper_low = wr_hit(sfr_addr_i, ADDR_UPPER_LOW, sfr_wr_i);
   assign wr_upper_high = wr_hit(sfr_addr_i, ADDR_UPPER_HIGH, sfr_wr_i);
   assign wr_lower_low = wr_hit(sfr_addr_i, ADDR_LOWER_LOW, sfr_wr_i);
   assign wr_lower_high = wr_hit(sfr_addr_i, ADDR_LOWER_HIGH, sfr_wr_i);
   assign wr_control = wr_hit(sfr_addr_i, ADDR_CONTROL, sfr_wr_i);

   result_formatter #(
      .WIDTH(WIDTH)
   ) u_formatter (
      .code_i(code_i),
      .left_i(left_justify_bit_r),
      .diff_i(diff_i),
      .word_o(new_word)
   );

   ////////////////////////////////////////////////////////////////////////
   // a result is taken on the first cycle busy is seen low after high
   // busy_prev resets low, so a converter idle through reset gives no false result
   always_comb begin
      busy_prev_nxt = conversion_busy_bit_i;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         busy_prev_r <= 1'b0;
      end else begin
         busy_prev_r <= busy_prev_nxt;
      end
   end

   assign new_result = busy_prev_r && !conversion_busy_bit_i;

   ////////////////////////////////////////////////////////////////////////
   // limits are compared in the layout of the word just formatted, so software
   // must program them in the same justification and signedness
   // both compares are strict: a word equal to a limit never matches
   assign upper_word = {upper_limit_high_byte_r, upper_limit_low_byte_r};
   assign lower_word = {lower_limit_high_byte_r, lower_limit_low_byte_r};

   always_comb begin
      above = less_than(upper_word, new_word, diff_i);
      below = less_than(new_word, lower_word, diff_i);
      inside_mode = less_than(upper_word, lower_word, diff_i);
      if (inside_mode) begin
         match = above && below;
      end else begin
         match = above || below;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // a fresh result overrides a software write in the same cycle
   always_comb begin
      result_low_byte_nxt = result_low_byte_r;
      result_high_byte_nxt = result_high_byte_r;
      if (wr_result_low) begin
         result_low_byte_nxt = sfr_wdata_i;
      end
      if (wr_result_high) begin
         result_high_byte_nxt = sfr_wdata_i;
      end
      if (new_result) begin
         result_high_byte_nxt = new_word[15:8];
         result_low_byte_nxt = new_word[7:0];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         result_low_byte_r <= RESET_RESULT;
         result_high_byte_r <= RESET_RESULT;
      end else begin
         result_low_byte_r <= result_low_byte_nxt;
         result_high_byte_r <= result_high_byte_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      upper_limit_low_byte_nxt = upper_limit_low_byte_r;
      upper_limit_high_byte_nxt = upper_limit_high_byte_r;
      if (wr_upper_low) begin
         upper_limit_low_byte_nxt = sfr_wdata_i;
      end
      if (wr_upper_high) begin
         upper_limit_high_byte_nxt = sfr_wdata_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         upper_limit_low_byte_r <= RESET_UPPER;
         upper_limit_high_byte_r <= RESET_UPPER;
      end else begin
         upper_limit_low_byte_r <= upper_limit_low_byte_nxt;
         upper_limit_high_byte_r <= upper_limit_high_byte_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      lower_limit_low_byte_nxt = lower_limit_low_byte_r;
      lower_limit_high_byte_nxt = lower_limit_high_byte_r;
      if (wr_lower_low) begin
         lower_limit_low_byte_nxt = sfr_wdata_i;
      end
      if (wr_lower_high) begin
         lower_limit_high_byte_nxt = sfr_wdata_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         lower_limit_low_byte_r <= RESET_LOWER;
         lower_limit_high_byte_r <= RESET_LOWER;
      end else begin
         lower_limit_low_byte_r <= lower_limit_low_byte_nxt;
         lower_limit_high_byte_r <= lower_limit_high_byte_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // justify select and the stored spare bits
   always_comb begin
      left_justify_bit_nxt = left_justify_bit_r;
      control_keep_nxt = control_keep_r;
      if (wr_control) begin
         left_justify_bit_nxt = sfr_wdata_i[BIT_LEFT_JUSTIFY];
         control_keep_nxt = sfr_wdata_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         left_justify_bit_r <= RESET_CONTROL[BIT_LEFT_JUSTIFY];
         control_keep_r <= RESET_CONTROL;
      end else begin
         left_justify_bit_r <= left_justify_bit_nxt;
         control_keep_r <= control_keep_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // writing 0 clears a flag; a hardware set in the same cycle still wins,
   // so an event is never lost to a clear that raced it
   always_comb begin
      window_match_flag_nxt = window_match_flag_r;
      conversion_done_flag_nxt = conversion_done_flag_r;
      if (wr_control) begin
         window_match_flag_nxt = sfr_wdata_i[BIT_WINDOW_MATCH];
         conversion_done_flag_nxt = sfr_wdata_i[BIT_DONE];
      end
      if (new_result) begin
         conversion_done_flag_nxt = 1'b1;
         if (match) begin
            window_match_flag_nxt = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         window_match_flag_r <= RESET_CONTROL[BIT_WINDOW_MATCH];
         conversion_done_flag_r <= RESET_CONTROL[BIT_DONE];
      end else begin
         window_match_flag_r <= window_match_flag_nxt;
         conversion_done_flag_r <= conversion_done_flag_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // the busy bit reads the converter's level as it stands
   always_comb begin
      control_view = control_keep_r;
      control_view[BIT_LEFT_JUSTIFY] = left_justify_bit_r;
      control_view[BIT_WINDOW_MATCH] = window_match_flag_r;
      control_view[BIT_BUSY] = conversion_busy_bit_i;
      control_view[BIT_DONE] = conversion_done_flag_r;
   end

   // read data is combinational and reads have no side effect, so polling is safe
   // unmapped addresses read zero
   always_comb begin
      sfr_rdata_o = 8'h00;
      if (sfr_rd_i) begin
         case (sfr_addr_i)
            ADDR_RESULT_LOW: sfr_rdata_o = result_low_byte_r;
            ADDR_RESULT_HIGH: sfr_rdata_o = result_high_byte_r;
            ADDR_UPPER_LOW: sfr_rdata_o = upper_limit_low_byte_r;
            ADDR_UPPER_HIGH: sfr_rdata_o = upper_limit_high_byte_r;
            ADDR_LOWER_LOW: sfr_rdata_o = lower_limit_low_byte_r;
            ADDR_LOWER_HIGH: sfr_rdata_o = lower_limit_high_byte_r;
            ADDR_CONTROL: sfr_rdata_o = control_view;
            default: sfr_rdata_o = 8'h00;
         endcase
      end
   end

   // interrupt requests follow the flags directly
   assign window_irq_o = window_match_flag_r;
   assign done_irq_o = conversion_done_flag_r;
   assign justify_select_o = left_justify_bit_r;
endmodule

// ===== core/adc_fmt_pkg.sv
package adc_fmt_pkg;
   localparam int RESULT_BITS = 10;
   // register addresses in special-function space
   localparam logic [7:0] ADDR_RESULT_LOW = 8'hBE;
   localparam logic [7:0] ADDR_RESULT_HIGH = 8'hBF;
   localparam logic [7:0] ADDR_UPPER_LOW = 8'hC4;
   localparam logic [7:0] ADDR_UPPER_HIGH = 8'hC5;
   localparam logic [7:0] ADDR_LOWER_LOW = 8'hC6;
   localparam logic [7:0] ADDR_LOWER_HIGH = 8'hC7;
   localparam logic [7:0] ADDR_CONTROL = 8'hE8;
   // control register bit positions
   localparam int BIT_LEFT_JUSTIFY = 0;
   localparam int BIT_WINDOW_MATCH = 1;
   localparam int BIT_BUSY = 4;
   localparam int BIT_DONE = 5;
   // reset values
   localparam logic [7:0] RESET_RESULT = 8'h00;
   localparam logic [7:0] RESET_UPPER = 8'hFF;
   localparam logic [7:0] RESET_LOWER = 8'h00;
   localparam logic [7:0] RESET_CONTROL = 8'h00;
endpackage

// ===== core/result_formatter.sv
`timescale 1ns/1ps
module result_formatter
   import adc_fmt_pkg::*;
#(
   parameter int WIDTH = RESULT_BITS
) (
   input wire logic [WIDTH-1:0] code_i,
   input wire logic left_i,
   input wire logic diff_i,
   output logic [15:0] word_o
);
   initial begin
      if (WIDTH != 10) $error("result_formatter serves a 10-bit code only");
   end
   always_comb begin
      if (left_i) begin
         word_o = {code_i, 6'h00};
      end else begin
         word_o = {{6{diff_i & code_i[WIDTH-1]}}, code_i};
      end
   end
endmodule

// ===== test/adc_fmt_props.sv
`timescale 1ns/1ps
module adc_fmt_props
   import adc_fmt_pkg::*;
#(
   parameter int WIDTH = RESULT_BITS
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [7:0] sfr_addr_i,
   input wire logic [7:0] sfr_wdata_i,
   input wire logic sfr_wr_i,
   input wire logic sfr_rd_i,
   input wire logic [7:0] sfr_rdata_o,
   input wire logic conversion_busy_bit_i,
   input wire logic [WIDTH-1:0] code_i,
   input wire logic diff_i,
   input wire logic window_irq_o,
   input wire logic done_irq_o,
   input wire logic justify_select_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic ctl_wr;
   assign ctl_wr = sfr_wr_i && sfr_addr_i == ADDR_CONTROL;
   AST_DONE_SET: assert property ($fell(conversion_busy_bit_i) && !$past(rst_i) |=> done_irq_o)
      else $error("done flag not set");
   AST_WIN_HOLD: assert property (window_irq_o && !ctl_wr |=> window_irq_o)
      else $error("window flag dropped");
   // a set needs a fresh result one sample back (busy high two samples back, low one back) or a software write
   AST_WIN_CAUSE: assert property ($rose(window_irq_o) |->
      $past(ctl_wr) || ($past(conversion_busy_bit_i, 2) && !$past(conversion_busy_bit_i)))
      else $error("window flag without cause");
   AST_JUST: assert property (ctl_wr |=> justify_select_o == $past(sfr_wdata_i[BIT_LEFT_JUSTIFY]))
      else $error("justify bit wrong");
   AST_RIGHT_LOW: assert property ($fell(conversion_busy_bit_i) && !$past(rst_i) && !justify_select_o
      ##1 sfr_rd_i && sfr_addr_i == ADDR_RESULT_LOW |-> sfr_rdata_o == $past(code_i[7:0]))
      else $error("right low byte wrong");
   AST_LEFT_LOW: assert property ($fell(conversion_busy_bit_i) && !$past(rst_i) && justify_select_o
      ##1 sfr_rd_i && sfr_addr_i == ADDR_RESULT_LOW |-> sfr_rdata_o == {$past(code_i[1:0]), 6'h00})
      else $error("left low byte wrong");
   AST_RIGHT_HIGH: assert property ($fell(conversion_busy_bit_i) && !$past(rst_i) && !justify_select_o
      ##2 sfr_rd_i && sfr_addr_i == ADDR_RESULT_HIGH |-> sfr_rdata_o ==
      {{6{$past(diff_i, 2) & $past(code_i[WIDTH-1], 2)}}, $past(code_i[WIDTH-1:WIDTH-2], 2)})
      else $error("right high byte wrong");
   AST_LEFT_HIGH: assert property ($fell(conversion_busy_bit_i) && !$past(rst_i) && justify_select_o
      ##2 sfr_rd_i && sfr_addr_i == ADDR_RESULT_HIGH |-> sfr_rdata_o == $past(code_i[WIDTH-1:WIDTH-8], 2))
      else $error("left high byte wrong");
endmodule
bind adc_result_format_window_detect adc_fmt_props #(.WIDTH(WIDTH)) u_props (.clk_i(clk_i), .rst_i(rst_i),
   .sfr_addr_i(sfr_addr_i), .sfr_wdata_i(sfr_wdata_i), .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i),
   .sfr_rdata_o(sfr_rdata_o), .conversion_busy_bit_i(conversion_busy_bit_i), .code_i(code_i),
   .diff_i(diff_i), .window_irq_o(window_irq_o), .done_irq_o(done_irq_o), .justify_select_o(justify_select_o));

// ===== test/adc_result_format_window_detect_tb.sv
`timescale 1ns/1ps
module adc_result_format_window_detect_tb;
   import adc_fmt_pkg::*;
   typedef struct packed {logic [1:0] m; logic [9:0] c; logic [15:0] w;} row_t;
   logic clk_i = 1'h0, rst_i = 1'h1, sfr_wr_i = 1'h0, sfr_rd_i = 1'h0, busy = 1'h0, diff_i = 1'h0;
   logic [7:0] sfr_addr_i = 8'h00, sfr_wdata_i = 8'h00, sfr_rdata_o;
   logic [9:0] code_i = 10'h000;
   logic window_irq_o, done_irq_o, justify_select_o;
   int err_total = 0, n_compared = 0, cyc = 0;
   // m: bit1 left justify, bit0 differential; default limits give unsigned rows a window over the whole range and signed rows an empty one, so no row flags
   row_t rows [12] = '{'{2'h0, 10'h3FF, 16'h03FF}, '{2'h0, 10'h200, 16'h0200}, '{2'h0, 10'h000, 16'h0000},
      '{2'h2, 10'h3FF, 16'hFFC0}, '{2'h2, 10'h1FF, 16'h7FC0}, '{2'h1, 10'h3FF, 16'hFFFF},
      '{2'h1, 10'h200, 16'hFE00}, '{2'h1, 10'h1FF, 16'h01FF}, '{2'h1, 10'h100, 16'h0100},
      '{2'h3, 10'h3FF, 16'hFFC0}, '{2'h3, 10'h200, 16'h8000}, '{2'h3, 10'h001, 16'h0040}};
   logic [7:0] ra [8] = '{ADDR_RESULT_LOW, ADDR_RESULT_HIGH, ADDR_UPPER_LOW, ADDR_UPPER_HIGH,
      ADDR_LOWER_LOW, ADDR_LOWER_HIGH, ADDR_CONTROL, 8'h10};
   logic [7:0] rv [8] = '{8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00};
   adc_result_format_window_detect DUT (.clk_i(clk_i), .rst_i(rst_i), .sfr_addr_i(sfr_addr_i),
      .sfr_wdata_i(sfr_wdata_i), .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i), .sfr_rdata_o(sfr_rdata_o),
      .conversion_busy_bit_i(busy), .code_i(code_i), .diff_i(diff_i), .window_irq_o(window_irq_o),
      .done_irq_o(done_irq_o), .justify_select_o(justify_select_o));
////////////////////////////////////////////////////////////////////////////////
   initial forever #5 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 2000) begin
         err_total++;
         results();
      end
   end
   task automatic results();
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic check(input logic [7:0] s, input logic [7:0] e);
      n_compared++;
      if (s !== e) begin
         err_total++;
         $display("[FAIL] %0t seen %h expected %h", $time, s, e);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      sfr_addr_i <= a;
      sfr_wdata_i <= d;
      sfr_wr_i <= 1'h1;
      @(posedge clk_i);
      sfr_wr_i <= 1'h0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk_i);
      sfr_addr_i <= a;
      sfr_rd_i <= 1'h1;
      #1 check(sfr_rdata_o, e);
      @(posedge clk_i);
      sfr_rd_i <= 1'h0;
   endtask
   // low byte is read first, right after the result lands
   task automatic conv(input row_t r, input logic ew);
      @(posedge clk_i);
      busy <= 1'h1;
      @(posedge clk_i);
      busy <= 1'h0;
      code_i <= r.c;
      diff_i <= r.m[0];
      @(posedge clk_i);
      sfr_addr_i <= ADDR_RESULT_LOW;
      sfr_rd_i <= 1'h1;
      #1 check(sfr_rdata_o, r.w[7:0]);
      @(posedge clk_i);
      sfr_addr_i <= ADDR_RESULT_HIGH;
      #1 check(sfr_rdata_o, r.w[15:8]);
      @(posedge clk_i);
      sfr_rd_i <= 1'h0;
      check({7'h00, window_irq_o}, {7'h00, ew});
      check({7'h00, done_irq_o}, 8'h01);
   endtask
   task automatic limits(input logic [15:0] up, input logic [15:0] lo);
      wr(ADDR_UPPER_HIGH, up[15:8]);
      wr(ADDR_UPPER_LOW, up[7:0]);
      wr(ADDR_LOWER_HIGH, lo[15:8]);
      wr(ADDR_LOWER_LOW, lo[7:0]);
      wr(ADDR_CONTROL, 8'h00);
   endtask
////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (16) @(posedge clk_i);
      rst_i <= 1'h0;
      foreach (rows[i]) begin
         wr(ADDR_CONTROL, {7'h00, rows[i].m[1]});
         conv(rows[i], 1'h0);
         check({7'h00, justify_select_o}, {7'h00, rows[i].m[1]});
      end
      rd(ADDR_CONTROL, 8'h21);
      limits(16'h0100, 16'h0080);
      conv('{2'h0, 10'h050, 16'h0050}, 1'h1);
      conv('{2'h0, 10'h0C0, 16'h00C0}, 1'h1);
      rd(ADDR_CONTROL, 8'h22);
      wr(ADDR_CONTROL, 8'h00);
      conv('{2'h0, 10'h100, 16'h0100}, 1'h0);
      conv('{2'h0, 10'h080, 16'h0080}, 1'h0);
      conv('{2'h0, 10'h200, 16'h0200}, 1'h1);
      limits(16'h0080, 16'h0100);
      conv('{2'h0, 10'h0C0, 16'h00C0}, 1'h1);
      wr(ADDR_CONTROL, 8'h00);
      conv('{2'h0, 10'h100, 16'h0100}, 1'h0);
      conv('{2'h0, 10'h080, 16'h0080}, 1'h0);
      limits(16'hFFF0, 16'h0010);
      conv('{2'h1, 10'h3FF, 16'hFFFF}, 1'h1);
      wr(ADDR_CONTROL, 8'h00);
      conv('{2'h1, 10'h3E0, 16'hFFE0}, 1'h0);
      rst_i <= 1'h1;
      repeat (16) @(posedge clk_i);
      rst_i <= 1'h0;
      foreach (ra[i]) rd(ra[i], rv[i]);
      results();
   end
endmodule
